// ---- design/brret_exec.sv ----
`timescale 1ns/1ns
// How it works
// - return from interrupt pops pc then status, stack pointer plus 4 each pop
// - return from interrupt has no delay slot; next instruction waits
// - level mask 16..31 adds 16 to a popped level 0..15
// - level mask 0..15 loads the popped level unchanged
// - popped status word sets stack select, enable and the four flags
// - return from interrupt takes two core cycles plus two memory accesses
// - taken branch target is own address plus 2 plus doubled short displacement
// - codes 0..7: always, never, Z, !Z, C, !C, N, !N
// - codes 8..15: V, !V, V^N, !(V^N), (V^N)|Z, negation, C|Z, !(C|Z)
// - false condition continues with the following instruction
// - plain branch has no slot; 2 cycles taken, 1 not taken
// - branch, jump and call leave N, Z, V and C unchanged
// - delayed jump loads pc from the source register, with a delay slot
// - the one delay-slot instruction runs before the branch target
// - delayed relative call: return pointer own+4, target own+2+doubled long disp
// - delayed register call: return pointer own+4, target from source register
// - delayed jump and calls issue in one cycle besides the slot
// - stack select clear makes the system stack pointer the active one
// - return address popped first, status word second
module brret_exec (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [brret_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [brret_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_INSN_VALID,
  input wire logic [15:0] I_INSN,
  input wire logic [31:0] I_SRC_REG,
  output logic O_INSN_READY,
  output logic [31:0] O_PC,
  output logic [31:0] O_RETURN_POINTER,
  output logic O_STK_REQ,
  output logic [31:0] O_STK_ADDR,
  input wire logic I_STK_ACK,
  input wire logic [31:0] I_STK_DATA
);
  import brret_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  brret_state_e state_q, state_d;
  logic [31:0] pc_q, pc_d, ps_q, ps_d, rp_q, rp_d;
  logic [31:0] ssp_q, ssp_d, usp_q, usp_d;
  logic [31:0] tgt_q, tgt_d, stk_addr_q, stk_addr_d;
  logic slot_q, slot_d, use_usp_q, use_usp_d;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire issue = I_INSN_VALID && O_INSN_READY;
  wire dec_ok = issue && !slot_q;
  wire is_return_from_interrupt = dec_ok && (I_INSN == OPC_RETURN_FROM_INTERRUPT);
  wire is_bcc = dec_ok && (I_INSN[15:12] == OPC_BCC);
  wire is_bccd = dec_ok && (I_INSN[15:12] == OPC_BCCD);
  wire is_calld = dec_ok && (I_INSN[15:11] == OPC_CALLD);
  wire is_jmpd = dec_ok && (I_INSN[15:4] == OPC_JMPD);
  wire is_callrd = dec_ok && (I_INSN[15:4] == OPC_CALLRD);
  wire [31:0] disp8 = {{23{I_INSN[7]}}, I_INSN[7:0], 1'b0};
  wire [31:0] disp11 = {{20{I_INSN[10]}}, I_INSN[10:0], 1'b0};
  wire [31:0] pc_next = pc_q + INSN_STEP;
  wire [31:0] br_tgt = pc_next + disp8;
  wire [31:0] call_tgt = pc_next + disp11;
  wire [31:0] ret_addr = pc_q + RET_STEP;
  wire cond_taken;
  wire pop_ack = I_STK_ACK && (state_q == ST_POP_PC || state_q == ST_POP_PS);
  wire [4:0] ilm_pop = I_STK_DATA[PS_ILM_HI:PS_ILM_LO];
  wire ilm_high = ps_q[PS_ILM_LO+ILM_UPPER];
  wire [4:0] ilm_new = {ilm_pop[ILM_UPPER] | ilm_high, ilm_pop[ILM_UPPER-1:0]};

  brret_cond_if cif ();
  assign cif.cc = I_INSN[11:8];
  assign cif.n = ps_q[CCR_N];
  assign cif.z = ps_q[CCR_N-1];
  assign cif.v = ps_q[CCR_C+1];
  assign cif.c = ps_q[CCR_C];
  assign cond_taken = cif.taken;
  brret_cond u_cond (.cif(cif));

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire wr_pc = wr_fire && awaddr_q == OFF_PC;
  wire wr_ps = wr_fire && awaddr_q == OFF_PS;
  wire wr_rp = wr_fire && awaddr_q == OFF_RP;
  wire wr_ssp = wr_fire && awaddr_q == OFF_SSP;
  wire wr_usp = wr_fire && awaddr_q == OFF_USP;
  wire wr_hit = wr_pc | wr_ps | wr_rp | wr_ssp | wr_usp | (awaddr_q == OFF_STATUS);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire rd_fire = I_ARVALID && O_ARREADY;
  wire busy = state_q != ST_IDLE;
  wire [31:0] status_w = {30'h0000_0000, slot_q, busy};
  wire rd_hit = I_ARADDR == OFF_PC || I_ARADDR == OFF_PS || I_ARADDR == OFF_RP
             || I_ARADDR == OFF_SSP || I_ARADDR == OFF_USP || I_ARADDR == OFF_STATUS;
  wire [31:0] rd_mux = I_ARADDR == OFF_PC ? pc_q :
                       I_ARADDR == OFF_PS ? ps_q :
                       I_ARADDR == OFF_RP ? rp_q :
                       I_ARADDR == OFF_SSP ? ssp_q :
                       I_ARADDR == OFF_USP ? usp_q :
                       I_ARADDR == OFF_STATUS ? status_w : 32'h0000_0000;

  assign O_AWREADY = !aw_held_q && !bvalid_q;
  assign O_WREADY = !w_held_q && !bvalid_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = !rvalid_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  assign O_INSN_READY = state_q == ST_IDLE;
  assign O_PC = pc_q;
  assign O_RETURN_POINTER = rp_q;
  assign O_STK_REQ = state_q == ST_POP_PC || state_q == ST_POP_PS;
  assign O_STK_ADDR = stk_addr_q;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    pc_d = wr_pc ? (pc_q & ~wmask) | (wdata_q & wmask) : pc_q;
    ps_d = wr_ps ? (ps_q & ~wmask) | (wdata_q & wmask) : ps_q;
    rp_d = wr_rp ? (rp_q & ~wmask) | (wdata_q & wmask) : rp_q;
    ssp_d = wr_ssp ? (ssp_q & ~wmask) | (wdata_q & wmask) : ssp_q;
    usp_d = wr_usp ? (usp_q & ~wmask) | (wdata_q & wmask) : usp_q;
    tgt_d = tgt_q;
    slot_d = slot_q;
    stk_addr_d = stk_addr_q;
    use_usp_d = use_usp_q;
    unique case (state_q)
      ST_IDLE: begin
        if (issue && slot_q) begin
          pc_d = tgt_q;
          slot_d = 1'b0;
        end else if (is_return_from_interrupt) begin
          state_d = ST_RETURN_FROM_INTERRUPT_START;
        end else if (is_bcc) begin
          if (cond_taken) begin
            pc_d = br_tgt;
            state_d = ST_BR_TAKEN;
          end else begin
            pc_d = pc_next;
          end
        end else if (is_bccd) begin
          pc_d = pc_next;
          slot_d = cond_taken;
          tgt_d = br_tgt;
        end else if (is_calld) begin
          pc_d = pc_next;
          rp_d = ret_addr;
          tgt_d = call_tgt;
          slot_d = 1'b1;
        end else if (is_jmpd || is_callrd) begin
          pc_d = pc_next;
          tgt_d = I_SRC_REG;
          slot_d = 1'b1;
          if (is_callrd) begin
            rp_d = ret_addr;
          end
        end else if (issue) begin
          pc_d = pc_next;
        end
      end
      ST_BR_TAKEN: state_d = ST_IDLE;
      ST_RETURN_FROM_INTERRUPT_START: begin
        use_usp_d = ps_q[CCR_S];
        stk_addr_d = ps_q[CCR_S] ? usp_q : ssp_q;
        state_d = ST_POP_PC;
      end
      ST_POP_PC: begin
        if (I_STK_ACK) begin
          pc_d = I_STK_DATA;
          stk_addr_d = stk_addr_q + STACK_STEP;
          state_d = ST_POP_PS;
        end
      end
      ST_POP_PS: begin
        if (I_STK_ACK) begin
          ps_d = I_STK_DATA;
          ps_d[PS_ILM_HI:PS_ILM_LO] = ilm_new;
          stk_addr_d = stk_addr_q + STACK_STEP;
          state_d = ST_RETURN_FROM_INTERRUPT_END;
        end
      end
      ST_RETURN_FROM_INTERRUPT_END: begin
        if (use_usp_q) begin
          usp_d = stk_addr_q;
        end else begin
          ssp_d = stk_addr_q;
        end
        state_d = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // core registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_q <= ST_IDLE;
      pc_q <= PC_RST;
      ps_q <= PS_RST;
      rp_q <= PC_RST;
      ssp_q <= SP_RST;
      usp_q <= SP_RST;
      tgt_q <= PC_RST;
      stk_addr_q <= SP_RST;
      slot_q <= 1'b0;
      use_usp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      ps_q <= ps_d;
      rp_q <= rp_d;
      ssp_q <= ssp_d;
      usp_q <= usp_d;
      tgt_q <= tgt_d;
      stk_addr_q <= stk_addr_d;
      slot_q <= slot_d;
      use_usp_q <= use_usp_d;
    end
  end

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= OFF_PC;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_pop_pc;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_q == ST_POP_PC && I_STK_ACK) |=>
      pc_q == $past(I_STK_DATA) && stk_addr_q == $past(stk_addr_q) + STACK_STEP;
  endproperty
  a_pop_pc: assert property (p_pop_pc) else $error("pc pop wrong");

  property p_return_from_interrupt_no_slot;
    @(posedge I_CLK) disable iff (!I_RST_N)
    is_return_from_interrupt |=> !O_INSN_READY [*3];
  endproperty
  a_return_from_interrupt_no_slot: assert property (p_return_from_interrupt_no_slot) else $error("return_from_interrupt slot taken");

  property p_ilm_clamp;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_q == ST_POP_PS && I_STK_ACK && ilm_high) |=> ps_q[PS_ILM_LO+ILM_UPPER];
  endproperty
  a_ilm_clamp: assert property (p_ilm_clamp) else $error("level mask left upper half");

  property p_ilm_free;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_q == ST_POP_PS && I_STK_ACK && !ilm_high) |=>
      ps_q[PS_ILM_HI:PS_ILM_LO] == $past(ilm_pop);
  endproperty
  a_ilm_free: assert property (p_ilm_free) else $error("level mask altered");

  property p_flags_pop;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_q == ST_POP_PS && I_STK_ACK) |=>
      ps_q[CCR_S:CCR_C] == $past(I_STK_DATA[CCR_S:CCR_C]) ##1 O_INSN_READY;
  endproperty
  a_flags_pop: assert property (p_flags_pop) else $error("flags not restored");

  property p_bcc_taken;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (is_bcc && cond_taken) |=> pc_q == $past(br_tgt) && !O_INSN_READY ##1 O_INSN_READY;
  endproperty
  a_bcc_taken: assert property (p_bcc_taken) else $error("taken branch wrong");

  property p_bcc_not;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (is_bcc && !cond_taken && !wr_pc) |=> pc_q == $past(pc_q) + INSN_STEP && O_INSN_READY;
  endproperty
  a_bcc_not: assert property (p_bcc_not) else $error("untaken branch wrong");

  property p_flags_keep;
    @(posedge I_CLK) disable iff (!I_RST_N)
    ((is_bcc || is_bccd || is_calld || is_jmpd || is_callrd) && !wr_ps) |=>
      ps_q[CCR_N:CCR_C] == $past(ps_q[CCR_N:CCR_C]);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("flags changed");

  property p_slot;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (is_jmpd && !wr_pc) |=> slot_q && pc_q == $past(pc_q) + INSN_STEP && tgt_q == $past(I_SRC_REG);
  endproperty
  a_slot: assert property (p_slot) else $error("delay slot skipped");

  property p_call_rp;
    @(posedge I_CLK) disable iff (!I_RST_N)
    is_calld |=> rp_q == $past(pc_q) + RET_STEP && tgt_q == $past(call_tgt) && O_INSN_READY;
  endproperty
  a_call_rp: assert property (p_call_rp) else $error("call return pointer wrong");

  c_return_from_interrupt: cover property (@(posedge I_CLK) disable iff (!I_RST_N) state_q == ST_RETURN_FROM_INTERRUPT_END);
  c_bcc: cover property (@(posedge I_CLK) disable iff (!I_RST_N) is_bcc && cond_taken);
  c_slot: cover property (@(posedge I_CLK) disable iff (!I_RST_N) issue && slot_q);
endmodule

// ---- design/brret_pkg.sv ----
package brret_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_PC = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RP = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SSP = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_USP = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // program status word layout
  // ---------------------------------------------------------------
  localparam int PS_ILM_LO = 16;
  localparam int PS_ILM_HI = 20;
  localparam int ILM_UPPER = 4;
  localparam int CCR_S = 5;
  localparam int CCR_N = 3;
  localparam int CCR_C = 0;
  // ---------------------------------------------------------------
  // reset values and steps
  // ---------------------------------------------------------------
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [31:0] PS_RST = 32'h0000_0000;
  localparam logic [31:0] SP_RST = 32'h0000_0000;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [31:0] INSN_STEP = 32'h0000_0002;
  localparam logic [31:0] RET_STEP = 32'h0000_0004;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [15:0] OPC_RETURN_FROM_INTERRUPT = 16'h9730;
  localparam logic [11:0] OPC_JMPD = 12'h9F0;
  localparam logic [11:0] OPC_CALLRD = 12'h9F1;
  localparam logic [3:0] OPC_BCC = 4'hE;
  localparam logic [3:0] OPC_BCCD = 4'hF;
  localparam logic [4:0] OPC_CALLD = 5'h1B;
  // ---------------------------------------------------------------
  // condition codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CC_RA = 4'h0, CC_NO = 4'h1, CC_EQ = 4'h2, CC_NE = 4'h3;
  localparam logic [3:0] CC_C = 4'h4, CC_NC = 4'h5, CC_N = 4'h6, CC_P = 4'h7;
  localparam logic [3:0] CC_V = 4'h8, CC_NV = 4'h9, CC_LT = 4'hA, CC_GE = 4'hB;
  localparam logic [3:0] CC_LE = 4'hC, CC_GT = 4'hD, CC_LS = 4'hE, CC_HI = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BR_TAKEN, ST_RETURN_FROM_INTERRUPT_START, ST_POP_PC, ST_POP_PS, ST_RETURN_FROM_INTERRUPT_END
  } brret_state_e;
endpackage

// ---- design/brret_cond_if.sv ----
`timescale 1ns/1ns
interface brret_cond_if;
  logic [3:0] cc;
  logic n;
  logic z;
  logic v;
  logic c;
  logic taken;
  modport eval (input cc, input n, input z, input v, input c, output taken);
  modport user (output cc, output n, output z, output v, output c, input taken);
endinterface

// ---- design/brret_cond.sv ----
`timescale 1ns/1ns
module brret_cond (
  brret_cond_if.eval cif
);
  import brret_pkg::*;

  always_comb begin
    unique case (cif.cc)
      CC_RA: cif.taken = 1'b1;
      CC_NO: cif.taken = 1'b0;
      CC_EQ: cif.taken = cif.z;
      CC_NE: cif.taken = !cif.z;
      CC_C: cif.taken = cif.c;
      CC_NC: cif.taken = !cif.c;
      CC_N: cif.taken = cif.n;
      CC_P: cif.taken = !cif.n;
      CC_V: cif.taken = cif.v;
      CC_NV: cif.taken = !cif.v;
      CC_LT: cif.taken = cif.v ^ cif.n;
      CC_GE: cif.taken = !(cif.v ^ cif.n);
      CC_LE: cif.taken = (cif.v ^ cif.n) | cif.z;
      CC_GT: cif.taken = !((cif.v ^ cif.n) | cif.z);
      CC_LS: cif.taken = cif.c | cif.z;
      CC_HI: cif.taken = !(cif.c | cif.z);
    endcase
  end
endmodule

// ---- tb/brret_stack_model.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// stack memory: one ack pulse per popped word, slow or prompt
// ---------------------------------------------------------------
module brret_stack_model (
  input wire logic i_clk,
  input wire logic i_stk_req,
  input wire logic [31:0] i_stk_addr,
  output logic o_stk_ack,
  output logic [31:0] o_stk_data
);
  logic [31:0] mem [0:15];
  logic [31:0] last_q = 32'h0;
  int delay = 0;
  int cnt = 0;

  initial begin
    o_stk_ack = 1'b0;
    o_stk_data = 32'h0;
  end

  // data bus shows the inverse of the last word outside an ack
  always @(posedge i_clk) begin
    if (i_stk_req && !o_stk_ack && cnt >= delay) begin
      o_stk_ack <= 1'b1;
      o_stk_data <= mem[i_stk_addr[5:2]];
      last_q <= mem[i_stk_addr[5:2]];
      cnt <= 0;
    end else begin
      o_stk_ack <= 1'b0;
      o_stk_data <= ~last_q;
      if (i_stk_req && !o_stk_ack) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ---- tb/tb_brret_exec.sv ----
`timescale 1ns/1ns
module tb_brret_exec;
  import brret_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_INSN_VALID, I_STK_ACK;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_INSN_READY, O_STK_REQ;
  logic [ADDR_W-1:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, I_SRC_REG, I_STK_DATA, O_RDATA, O_PC, O_RETURN_POINTER, O_STK_ADDR;
  logic [3:0] I_WSTRB;
  logic [1:0] O_BRESP, O_RRESP;
  logic [15:0] I_INSN;
  int mismatches = 0;
  int n_compared = 0;
  logic [ADDR_W-1:0] reg_offs [5] = '{OFF_PC, OFF_PS, OFF_RP, OFF_SSP, OFF_USP};
  logic [15:0] dl_op [4] = '{{OPC_JMPD, 4'h1}, {OPC_CALLRD, 4'h3}, {OPC_CALLD, 11'h400},
                             {OPC_BCCD, 4'h0, 8'h10}};
  logic [31:0] dl_src [4] = '{32'h0000_3000, 32'h0000_4A20, 32'h0000_7777, 32'h0};
  logic [31:0] dl_tgt [4] = '{32'h0000_3000, 32'h0000_4A20, 32'h0000_0802, 32'h0000_1022};
  logic [31:0] dl_rp [4] = '{32'h0, 32'h0000_1004, 32'h0000_1004, 32'h0};

  always #50 I_CLK = ~I_CLK;

  brret_exec brret_exec_inst (
    .I_CLK, .I_RST_N, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID,
    .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
    .O_RRESP, .O_RVALID, .I_RREADY, .I_INSN_VALID, .I_INSN, .I_SRC_REG, .O_INSN_READY, .O_PC,
    .O_RETURN_POINTER, .O_STK_REQ, .O_STK_ADDR, .I_STK_ACK, .I_STK_DATA
  );

  brret_stack_model brret_stack_model_inst (
    .i_clk(I_CLK), .i_stk_req(O_STK_REQ), .i_stk_addr(O_STK_ADDR),
    .o_stk_ack(I_STK_ACK), .o_stk_data(I_STK_DATA)
  );

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic wrap_up;
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timed_out;
    mismatches++;
    wrap_up();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // bus and instruction drivers
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    r = 2'h3;
    @(posedge I_CLK);
    I_AWADDR <= a;
    I_AWVALID <= 1'b1;
    I_WDATA <= d;
    I_WSTRB <= s;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge I_CLK);
      if (aw_ok && w_ok && O_BVALID === 1'b1) begin
        r = O_BRESP;
        break;
      end
      if (!aw_ok && O_AWREADY === 1'b1) begin
        aw_ok = 1;
        I_AWVALID <= 1'b0;
      end
      if (!w_ok && O_WREADY === 1'b1) begin
        w_ok = 1;
        I_WVALID <= 1'b0;
      end
    end
    I_BREADY <= 1'b0;
    if (n == 64) timed_out();
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    bit ar_ok;
    int n;
    ar_ok = 0;
    @(posedge I_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge I_CLK);
      if (ar_ok && O_RVALID === 1'b1) begin
        d = O_RDATA;
        r = O_RRESP;
        break;
      end
      if (!ar_ok && O_ARREADY === 1'b1) begin
        ar_ok = 1;
        I_ARVALID <= 1'b0;
      end
    end
    I_RREADY <= 1'b0;
    if (n == 64) timed_out();
  endtask

  // low counts the cycles with the instruction port refused after the take
  task automatic issue(input logic [15:0] op, input logic [31:0] src, output int low);
    int n;
    low = 0;
    @(posedge I_CLK);
    I_INSN <= op;
    I_SRC_REG <= src;
    I_INSN_VALID <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge I_CLK);
      if (O_INSN_READY === 1'b1) break;
    end
    if (n == 64) timed_out();
    I_INSN_VALID <= 1'b0;
    for (n = 0; n < 64; n++) begin
      @(negedge I_CLK);
      if (O_INSN_READY === 1'b1) break;
      low++;
    end
    if (n == 64) timed_out();
  endtask

  function automatic logic cond(input logic [3:0] cc, input logic [3:0] f);
    logic b;
    case (cc[3:1])
      3'h0: b = 1'b1;
      3'h1: b = f[2];
      3'h2: b = f[0];
      3'h3: b = f[3];
      3'h4: b = f[1];
      3'h5: b = f[1] ^ f[3];
      3'h6: b = (f[1] ^ f[3]) | f[2];
      default: b = f[0] | f[2];
    endcase
    return b ^ cc[0];
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_regs;
    logic [31:0] d;
    logic [1:0] r;
    foreach (reg_offs[i]) begin
      axi_read(reg_offs[i], d, r);
      check(d, 32'h0);
      check({30'h0, r}, {30'h0, RESP_OKAY});
    end
    axi_read(8'h40, d, r);
    check({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_write(8'h40, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(OFF_RP, 32'h1111_2222, 4'hF, r);
    axi_write(OFF_RP, 32'hAAAA_BBBB, 4'h3, r);
    axi_read(OFF_RP, d, r);
    check(d, 32'h1111_BBBB);
    check(O_RETURN_POINTER, 32'h1111_BBBB);
    axi_write(OFF_STATUS, 32'hFFFF_FFFF, 4'hF, r);
    axi_read(OFF_STATUS, d, r);
    check(d, 32'h0);
  endtask

  task automatic sc_bcc;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] f;
    logic tk;
    int low;
    for (int k = 0; k < 2; k++) begin
      f = (k == 0) ? 4'h5 : 4'hA;
      for (int cc = 0; cc < 16; cc++) begin
        axi_write(OFF_PS, {28'h0, f}, 4'hF, r);
        axi_write(OFF_PC, 32'h0000_2000, 4'hF, r);
        issue({OPC_BCC, cc[3:0], 8'hF0}, 32'h0, low);
        tk = cond(cc[3:0], f);
        check(O_PC, tk ? 32'h0000_1FE2 : 32'h0000_2002);
        check(32'(low), tk ? 32'h1 : 32'h0);
      end
      axi_read(OFF_PS, d, r);
      check({28'h0, d[3:0]}, {28'h0, f});
    end
  endtask

  // the slot holds a branch opcode, which must not steer the flow
  task automatic sc_delayed;
    logic [1:0] r;
    int low;
    for (int i = 0; i < 4; i++) begin
      axi_write(OFF_PC, 32'h0000_1000, 4'hF, r);
      axi_write(OFF_RP, 32'h0, 4'hF, r);
      issue(dl_op[i], dl_src[i], low);
      check(32'(low), 32'h0);
      check(O_PC, 32'h0000_1002);
      check(O_RETURN_POINTER, dl_rp[i]);
      issue({OPC_BCC, 4'h0, 8'h10}, 32'h0, low);
      check(O_PC, dl_tgt[i]);
    end
  endtask

  task automatic sc_return_from_interrupt(input logic [4:0] cur, input logic [4:0] pil, input logic [5:0] lo,
                         input int dly, input logic [4:0] exp_ilm);
    logic [31:0] d;
    logic [1:0] r;
    int low;
    axi_write(OFF_SSP, 32'h0000_0020, 4'hF, r);
    axi_write(OFF_USP, 32'h0000_0060, 4'hF, r);
    axi_write(OFF_PS, {11'h0, cur, 16'h0}, 4'hF, r);
    brret_stack_model_inst.mem[8] = 32'h0000_5678;
    brret_stack_model_inst.mem[9] = {11'h0, pil, 10'h0, lo};
    brret_stack_model_inst.delay = dly;
    issue(OPC_RETURN_FROM_INTERRUPT, 32'h0, low);
    check(32'(low), 32'(2 + 2 * (dly + 2)));
    check(O_PC, 32'h0000_5678);
    axi_read(OFF_PS, d, r);
    check({21'h0, d[20:16], d[5:0]}, {21'h0, exp_ilm, lo});
    axi_read(OFF_SSP, d, r);
    check(d, 32'h0000_0028);
    axi_read(OFF_USP, d, r);
    check(d, 32'h0000_0060);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    I_RST_N = 1'b0;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_INSN_VALID} = 6'h0;
    I_AWADDR = '0;
    I_ARADDR = '0;
    I_WDATA = 32'h0;
    I_WSTRB = 4'hF;
    I_INSN = 16'h0;
    I_SRC_REG = 32'h0;
    repeat (16) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    sc_regs();
    sc_bcc();
    sc_delayed();
    sc_return_from_interrupt(5'h10, 5'h03, 6'h31, 0, 5'h13);
    sc_return_from_interrupt(5'h1F, 5'h1A, 6'h0E, 2, 5'h1A);
    sc_return_from_interrupt(5'h0F, 5'h02, 6'h15, 1, 5'h02);
    sc_return_from_interrupt(5'h00, 5'h1F, 6'h2A, 0, 5'h1F);
    wrap_up();
  end
endmodule
